// file: sim/dfr_mod_model.sv
module dfr_mod_model
    import dfr_pkg::*;
(
    output logic o_link_clk,
    input wire dfr_pkg::dfr_chan_type i_chan
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Modulator side of the channel pair
    // ------------------------------------------------------------
    dfr_chan_type samp[$];
    logic q_skew_q;

    // Bit clock source.
    // The odd start offset keeps this clock unrelated in phase to i_clk.
    initial begin
        o_link_clk = 1'b0;
        #3.7;
        forever #6 o_link_clk = ~o_link_clk;
    end

    always @(posedge o_link_clk) begin
        q_skew_q <= i_chan.q;
    end

    // Recombination sample log.
    // Sampling on the falling edge keeps clear of the launching edge. Each
    // I bit spans two samples, and each skewed Q bit one sample later.
    always @(negedge o_link_clk) begin
        samp.push_back(dfr_chan_type'({i_chan.i, q_skew_q}));
    end
endmodule

// file: sim/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dfr_pkg::*;

    // ------------------------------------------------------------
    // Bench signals
    // ------------------------------------------------------------
    // Marker value is arbitrary.
    localparam logic [31:0] MARKER = 32'hB5C3_3C5A;
    localparam int FB = FRAME_BITS;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_test_mode = 1'b0;
    dfr_octet_type i_octet = '0;
    logic link_clk;
    logic o_octet_ready;
    logic o_underflow;
    dfr_chan_type o_chan;
    int failures = 0;
    int n_checks = 0;
    int s0 = 0;

    initial begin
        forever #50 i_clk = ~i_clk;
    end

    dfr_top #(.SYNC_MARKER(MARKER)) dut (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_link_clk(link_clk),
        .i_test_mode(i_test_mode),
        .i_octet(i_octet),
        .o_octet_ready(o_octet_ready),
        .o_underflow(o_underflow),
        .o_chan(o_chan)
    );

    dfr_mod_model mdl (
        .o_link_clk(link_clk),
        .i_chan(o_chan)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [39:0] seen, logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Serial bit n counted from the first marker bit of the first frame.
    function automatic logic bit_at(int n);
        dfr_chan_type c;
        c = mdl.samp[s0 + n];
        return (n % 2 == 0) ? c.i : c.q;
    endfunction

    function automatic logic [39:0] bits40(int n);
        logic [39:0] v;
        for (int b = 0; b < 40; b++) begin
            v[39-b] = bit_at(n + b);
        end
        return v;
    endfunction

    task automatic wait_bits(int n);
        int k;
        k = 0;
        while (mdl.samp.size() <= s0 + n + 2 && k < 5000) begin
            @(negedge i_clk);
            k++;
        end
        check("bit wait limit", 40'(k >= 5000), 40'h0);
    endtask

    task automatic feed(logic [7:0] d);
        int k;
        k = 0;
        while (o_octet_ready !== 1'b1 && k < 1000) begin
            @(negedge i_clk);
            k++;
        end
        check("octet wait limit", 40'(k >= 1000), 40'h0);
        i_octet <= '{valid: 1'b1, data: d};
        @(posedge i_clk);
        @(negedge i_clk);
        i_octet <= '0;
        check("ready after take", 40'(o_octet_ready), 40'h0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic first_frame();
        logic [39:0] got;
        int errs;
        errs = 0;
        wait_bits(400);
        for (int s = 1; s < 300; s++) begin
            s0 = s;
            got = bits40(0);
            if (got[39:8] === MARKER) break;
        end
        check("sync marker", 40'(got[39:8]), 40'(MARKER));
        wait_bits(80);
        // Nothing was offered, so the body is fill and shows the generator.
        check("first body bits", bits40(32), PRBS_HEAD);
        repeat (4) @(negedge i_clk);
        check("underflow flag", 40'(o_underflow), 40'h1);
        wait_bits(4002);
        for (int p = 16; p < 2000; p++) begin
            if (mdl.samp[s0 + 2 * p].i !== mdl.samp[s0 + 2 * p + 1].i
                || mdl.samp[s0 + 2 * p + 1].q
                   !== mdl.samp[s0 + 2 * p + 2].q) begin
                errs++;
            end
        end
        check("channel hold errors", 40'(errs), 40'h0);
    endtask

    task automatic second_frame();
        logic [39:0] want;
        want = PRBS_HEAD ^ {8'h3C, 32'h0};
        wait_bits(int'(PARITY_FIRST_BIT) + 16);
        feed(8'h3C);
        wait_bits(FB + 80);
        check("frame length marker", bits40(FB) >> 8, 40'(MARKER));
        check("reloaded body", bits40(FB + 32), want);
        i_test_mode <= 1'b1;
    endtask

    task automatic test_stream();
        int base;
        int errs;
        int rep;
        int ones;
        base = 2 * FB;
        errs = 0;
        rep = 0;
        ones = 0;
        wait_bits(base + 900);
        for (int n = base; n < base + 600; n++) begin
            if (bit_at(n + 8) !== (bit_at(n + 7) ^ bit_at(n + 5)
                                   ^ bit_at(n + 3) ^ bit_at(n))) begin
                errs++;
            end
            if (bit_at(n) !== bit_at(n + 255)) begin
                rep++;
            end
        end
        for (int n = base; n < base + 255; n++) begin
            ones += 32'(bit_at(n));
        end
        check("test stream recurrence", 40'(errs), 40'h0);
        check("test stream period", 40'(rep), 40'h0);
        check("ones per period", 40'(ones), 40'd128);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(negedge i_clk);
        check("underflow in reset", 40'(o_underflow), 40'h0);
        i_rst <= 1'b0;
        first_frame();
        second_frame();
        test_stream();
        conclude();
    end

    initial begin
        #2_000_000;
        failures++;
        conclude();
    end
endmodule

// file: src/dfr_pkg.sv
package dfr_pkg;

    // ------------------------------------------------------------
    // Frame layout, in octets
    // ------------------------------------------------------------
    localparam int OCTET_W = 8;
    localparam int SYNC_OCTETS = 4;
    localparam int PRI_HDR_OCTETS = 6;
    localparam int MUX_HDR_OCTETS = 2;
    localparam int ZONE_OCTETS = 884;
    localparam int PARITY_OCTETS = 128;
    localparam int BODY_OCTETS = PRI_HDR_OCTETS + MUX_HDR_OCTETS
                                 + ZONE_OCTETS;
    localparam int FRAME_OCTETS = SYNC_OCTETS + BODY_OCTETS + PARITY_OCTETS;
    localparam int SYNC_BITS = SYNC_OCTETS * OCTET_W;
    localparam int FRAME_BITS = FRAME_OCTETS * OCTET_W;
    localparam int CNT_W = $clog2(FRAME_BITS);
    localparam int OCT_BIT_W = $clog2(OCTET_W);
    localparam int SYNC_IDX_W = $clog2(SYNC_OCTETS);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_BITS - 1);
    localparam logic [CNT_W-1:0] BODY_FIRST_BIT = CNT_W'(SYNC_BITS);
    localparam logic [CNT_W-1:0] PARITY_FIRST_BIT =
        CNT_W'((SYNC_OCTETS + BODY_OCTETS) * OCTET_W);
    localparam logic [OCTET_W-1:0] FILL_OCTET = 8'h00;

    // ------------------------------------------------------------
    // Link rates
    // ------------------------------------------------------------
    localparam int LINK_RATE_BPS = 15_000_000;
    localparam int LINK_RATE_TOL_BPS = 1_800;
    localparam int BITS_PER_PAIR = 2;
    localparam int CHAN_RATE_BPS = LINK_RATE_BPS / BITS_PER_PAIR;

    // ------------------------------------------------------------
    // Pseudo-random generator
    // ------------------------------------------------------------
    localparam int PRBS_W = 8;
    localparam logic [PRBS_W-1:0] PRBS_SEED = 8'hFF;
    // Taps x^8 + x^7 + x^5 + x^3 + 1 on a shift register whose bit 0 is
    // the oldest output.
    localparam logic [PRBS_W-1:0] PRBS_TAPS = 8'hA9;
    localparam int PRBS_PERIOD = 255;
    localparam int PRBS_HEAD_LEN = 40;
    localparam logic [PRBS_HEAD_LEN-1:0] PRBS_HEAD = 40'hFF_480E_C09A;

    // ------------------------------------------------------------
    // Reed-Solomon code
    // ------------------------------------------------------------
    localparam int RS_N = 255;
    localparam int RS_K = 223;
    localparam int RS_PARITY = RS_N - RS_K;
    localparam int RS_DEPTH = 4;
    localparam int IL_W = $clog2(RS_DEPTH);
    localparam logic [OCTET_W-1:0] GF_POLY_LOW = 8'h87;
    localparam logic [OCTET_W-1:0] RS_FIRST_ROOT = 8'h01;
    localparam logic [OCTET_W-1:0] RS_ALPHA = 8'h02;

    typedef struct packed {
        logic valid;
        logic [OCTET_W-1:0] data;
    } dfr_octet_type;

    typedef struct packed {
        logic i;
        logic q;
    } dfr_chan_type;

    function automatic logic [OCTET_W-1:0] gf_mul(
        input logic [OCTET_W-1:0] a_in,
        input logic [OCTET_W-1:0] b_in
    );
        logic [OCTET_W-1:0] a;
        logic [OCTET_W-1:0] p;
        a = a_in;
        p = '0;
        for (int i = 0; i < OCTET_W; i++) begin
            if (b_in[i]) begin
                p = p ^ a;
            end
            a = {a[OCTET_W-2:0], 1'b0} ^ (a[OCTET_W-1] ? GF_POLY_LOW : 8'h00);
        end
        return p;
    endfunction

    // Coefficients below the implicit leading one, lowest first.
    function automatic logic [RS_PARITY*OCTET_W-1:0] rs_gen_poly();
        logic [OCTET_W-1:0] g [0:RS_PARITY];
        logic [OCTET_W-1:0] root;
        logic [RS_PARITY*OCTET_W-1:0] res;
        root = RS_FIRST_ROOT;
        g[0] = 8'h01;
        for (int i = 1; i <= RS_PARITY; i++) begin
            g[i] = 8'h00;
        end
        for (int j = 0; j < RS_PARITY; j++) begin
            for (int i = RS_PARITY; i > 0; i--) begin
                g[i] = g[i-1] ^ gf_mul(g[i], root);
            end
            g[0] = gf_mul(g[0], root);
            root = gf_mul(root, RS_ALPHA);
        end
        for (int i = 0; i < RS_PARITY; i++) begin
            res[i*OCTET_W +: OCTET_W] = g[i];
        end
        return res;
    endfunction

endpackage

// file: src/dfr_prbs.sv
module dfr_prbs #(
    parameter int WIDTH = dfr_pkg::PRBS_W
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic i_step,
    output logic o_bit
);
    import dfr_pkg::*;

    logic [WIDTH-1:0] state_q;
    logic [WIDTH-1:0] state_d;

    always_comb begin
        state_d = state_q;
        if (i_load) begin
            state_d = PRBS_SEED;
        end else if (i_step) begin
            state_d = {^(state_q & PRBS_TAPS), state_q[WIDTH-1:1]};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= PRBS_SEED;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_bit = state_q[0];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [7:0] run_q;
    logic [7:0] run_d;

    always_comb begin
        run_d = run_q;
        if (i_load) begin
            run_d = 8'h00;
        end else if (i_step && run_q != 8'hFF) begin
            run_d = run_q + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            run_q <= 8'h00;
        end else begin
            run_q <= run_d;
        end
    end

    a_prbs_period: assert property (@(posedge i_clk) disable iff (i_rst)
        (run_q == 8'hFF && $past(i_step, 1) && i_step)
        |-> state_q == $past(state_q, 255))
        else $error("generator period is not 255 bits");

endmodule

// file: src/dfr_rs_enc.sv
module dfr_rs_enc #(
    parameter int DEPTH = dfr_pkg::RS_DEPTH,
    parameter int NPAR = dfr_pkg::RS_PARITY
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_feed,
    input wire logic i_shift,
    input wire logic [dfr_pkg::IL_W-1:0] i_sel,
    input wire logic [dfr_pkg::OCTET_W-1:0] i_data,
    output logic [dfr_pkg::OCTET_W-1:0] o_parity
);
    import dfr_pkg::*;

    localparam logic [NPAR*OCTET_W-1:0] GEN = rs_gen_poly();

    logic [OCTET_W-1:0] par_q [DEPTH][NPAR];
    logic [OCTET_W-1:0] par_d [DEPTH][NPAR];
    logic [OCTET_W-1:0] fb;

    // One remainder register per interleaved codeword.
    always_comb begin
        par_d = par_q;
        fb = par_q[i_sel][NPAR-1] ^ (i_feed ? i_data : FILL_OCTET);
        if (i_clear) begin
            for (int c = 0; c < DEPTH; c++) begin
                for (int i = 0; i < NPAR; i++) begin
                    par_d[c][i] = 8'h00;
                end
            end
        end else if (i_feed || i_shift) begin
            // A shift is a feed with the feedback held at zero.
            for (int i = 0; i < NPAR; i++) begin
                par_d[i_sel][i] =
                    (i == 0 ? 8'h00 : par_q[i_sel][i-1])
                    ^ (i_feed ? gf_mul(fb, GEN[i*OCTET_W +: OCTET_W])
                              : 8'h00);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int c = 0; c < DEPTH; c++) begin
                for (int i = 0; i < NPAR; i++) begin
                    par_q[c][i] <= 8'h00;
                end
            end
        end else begin
            par_q <= par_d;
        end
    end

    assign o_parity = par_q[i_sel][NPAR-1];

endmodule

// file: src/dfr_top.sv
// Contract
// - Link carries fifteen megabits per second in both modes.
// - Serial stream split alternately into I and Q, half rate each.
// - Each channel holds its level for the whole channel bit.
// - Science frames and test stream never run together.
// - Test mode sends locally generated pseudo-random bits on both channels.
// - Test stream carries no headers or frame formatting.
// - Frame: 4 sync, 6 header, 2 mux header, 884 zone, 128 parity.
// - Parity from (255,223) Reed-Solomon code interleaved to depth four.
// - Generator polynomial is x^8 + x^7 + x^5 + x^3 + 1.
// - Generated sequence repeats every 255 bits.
// - Generator reloads all ones during every sync marker.
// - First generator bit after reload XORs first frame body bit.
// - Generator output starts with the given 40-bit pattern.
// - Bit rate within 1.8 kbps of nominal, set by link clock.
module dfr_top #(
    // Arbitrary default; set to the marker the ground station expects.
    parameter logic [dfr_pkg::SYNC_BITS-1:0] SYNC_MARKER = 32'hF0F0_0F0F
)(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_test_mode,
    input dfr_pkg::dfr_octet_type i_octet,
    output logic o_octet_ready,
    output logic o_underflow,
    output dfr_pkg::dfr_chan_type o_chan
);
    import dfr_pkg::*;

    // ------------------------------------------------------------
    // System clock side: octet hand-off
    // ------------------------------------------------------------
    logic l_req_q;
    logic l_unf_q;
    logic [1:0] s_req_q;
    logic [1:0] s_req_d;
    logic [1:0] s_unf_q;
    logic [1:0] s_unf_d;
    logic s_ack_q;
    logic s_ack_d;
    logic [OCTET_W-1:0] s_data_q;
    logic [OCTET_W-1:0] s_data_d;
    logic s_pending;

    assign s_pending = s_req_q[1] != s_ack_q;

    always_comb begin
        s_req_d = {s_req_q[0], l_req_q};
        s_unf_d = {s_unf_q[0], l_unf_q};
        s_ack_d = s_ack_q;
        s_data_d = s_data_q;
        if (s_pending && i_octet.valid) begin
            s_ack_d = ~s_ack_q;
            s_data_d = i_octet.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_req_q <= 2'h0;
            s_unf_q <= 2'h0;
            s_ack_q <= 1'b0;
            s_data_q <= 8'h00;
        end else begin
            s_req_q <= s_req_d;
            s_unf_q <= s_unf_d;
            s_ack_q <= s_ack_d;
            s_data_q <= s_data_d;
        end
    end

    assign o_octet_ready = s_pending;
    assign o_underflow = s_unf_q[1];

    // ------------------------------------------------------------
    // Link clock side: synchronisers
    // ------------------------------------------------------------
    // Bits are {reset, test mode, ack toggle}. The reset crosses here too,
    // so these two stages carry no reset of their own.
    logic [2:0] l_sync1_q;
    logic [2:0] l_sync2_q;
    logic l_rst;
    logic l_test;
    logic l_ack;

    always_ff @(posedge i_link_clk) begin
        l_sync1_q <= {i_rst, i_test_mode, s_ack_q};
        l_sync2_q <= l_sync1_q;
    end

    assign l_rst = l_sync2_q[2];
    assign l_test = l_sync2_q[1];
    assign l_ack = l_sync2_q[0];

    // ------------------------------------------------------------
    // Link clock side: frame sequencer and serializer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] pos_q;
    logic [OCTET_W-1:0] sh_q;
    logic [OCTET_W-1:0] sh_d;
    logic ser_q;
    logic ser_d;
    logic pend_q;
    logic pend_d;
    dfr_chan_type chan_q;
    dfr_chan_type chan_d;
    logic mode_q;
    logic mode_d;
    logic [OCTET_W-1:0] hold_q;
    logic [OCTET_W-1:0] hold_d;
    logic full_q;
    logic full_d;
    logic wait_q;
    logic wait_d;
    logic l_req_d;
    logic ack_seen_q;
    logic l_unf_d;
    logic in_sync;
    logic in_body;
    logic in_parity;
    logic oct_start;
    logic ack_edge;
    logic raw;
    logic prbs_bit;
    logic prbs_load;
    logic rs_clear;
    logic rs_feed;
    logic rs_shift;
    logic [IL_W-1:0] il_sel;
    logic [SYNC_IDX_W-1:0] sync_idx;
    logic [OCTET_W-1:0] sync_oct;
    logic [OCTET_W-1:0] body_oct;
    logic [OCTET_W-1:0] rs_oct;
    logic [OCTET_W-1:0] oct_val;

    assign in_sync = cnt_q < BODY_FIRST_BIT;
    assign in_parity = cnt_q >= PARITY_FIRST_BIT;
    assign in_body = !in_sync && !in_parity;
    assign oct_start = cnt_q[OCT_BIT_W-1:0] == '0;
    assign ack_edge = l_ack != ack_seen_q;
    // The sync field is a whole multiple of the interleave depth long, so the
    // octet index picks the interleaved codeword directly.
    assign il_sel = cnt_q[OCT_BIT_W +: IL_W];
    assign sync_idx = cnt_q[OCT_BIT_W +: SYNC_IDX_W];
    assign sync_oct =
        SYNC_MARKER[(SYNC_OCTETS - 1 - int'(sync_idx)) * OCTET_W +: OCTET_W];
    assign body_oct = full_q ? hold_q : FILL_OCTET;
    // Octet source follows the frame layout.
    assign oct_val = in_sync ? sync_oct : (in_body ? body_oct : rs_oct);
    assign raw = oct_start ? oct_val[OCTET_W-1] : sh_q[OCTET_W-1];
    // Reload the generator across the whole sync marker.
    assign prbs_load = !mode_q && in_sync;
    // Test mode bypasses frame building and coding.
    assign rs_clear = !mode_q && cnt_q == CNT_ZERO;
    assign rs_feed = !mode_q && in_body && oct_start;
    assign rs_shift = !mode_q && in_parity && oct_start;

    always_comb begin
        // One serial bit per link clock edge; rate is the clock's.
        cnt_d = (cnt_q == CNT_LAST) ? CNT_ZERO : cnt_q + CNT_ONE;
        sh_d = oct_start ? {oct_val[OCTET_W-2:0], 1'b0}
                         : {sh_q[OCTET_W-2:0], 1'b0};
        mode_d = (cnt_q == CNT_LAST) ? l_test : mode_q;
        if (mode_q) begin
            // Test stream is the generator output itself.
            ser_d = prbs_bit;
        end else if (in_sync) begin
            ser_d = raw;
        end else begin
            // Body and parity are XORed bit for bit from reload.
            ser_d = raw ^ prbs_bit;
        end
        pend_d = pend_q;
        chan_d = chan_q;
        // Even serial bit to I, odd serial bit to Q.
        if (!pos_q[0]) begin
            pend_d = ser_q;
        end else begin
            // Both channels change once per serial pair.
            chan_d.i = pend_q;
            chan_d.q = ser_q;
        end
        hold_d = hold_q;
        full_d = full_q && !rs_feed;
        wait_d = wait_q;
        l_req_d = l_req_q;
        // A missing octet is replaced by fill so the frame keeps its rate.
        l_unf_d = l_unf_q || (rs_feed && !full_q);
        if (ack_edge) begin
            hold_d = s_data_q;
            full_d = 1'b1;
            wait_d = 1'b0;
        end else if (!full_q && !wait_q) begin
            l_req_d = ~l_req_q;
            wait_d = 1'b1;
        end
    end

    always_ff @(posedge i_link_clk) begin
        if (l_rst) begin
            cnt_q <= CNT_ZERO;
            pos_q <= CNT_ZERO;
            sh_q <= 8'h00;
            ser_q <= 1'b0;
            pend_q <= 1'b0;
            chan_q <= '0;
            mode_q <= 1'b0;
            hold_q <= 8'h00;
            full_q <= 1'b0;
            wait_q <= 1'b0;
            l_req_q <= 1'b0;
            ack_seen_q <= 1'b0;
            l_unf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pos_q <= cnt_q;
            sh_q <= sh_d;
            ser_q <= ser_d;
            pend_q <= pend_d;
            chan_q <= chan_d;
            mode_q <= mode_d;
            hold_q <= hold_d;
            full_q <= full_d;
            wait_q <= wait_d;
            l_req_q <= l_req_d;
            ack_seen_q <= l_ack;
            l_unf_q <= l_unf_d;
        end
    end

    assign o_chan = chan_q;

    dfr_prbs u_prbs (
        .i_clk(i_link_clk),
        .i_rst(l_rst),
        .i_load(prbs_load),
        .i_step(!prbs_load),
        .o_bit(prbs_bit)
    );

    dfr_rs_enc u_rs (
        .i_clk(i_link_clk),
        .i_rst(l_rst),
        .i_clear(rs_clear),
        .i_feed(rs_feed),
        .i_shift(rs_shift),
        .i_sel(il_sel),
        .i_data(body_oct),
        .o_parity(rs_oct)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] feed_cnt_q;
    int head_idx;

    assign head_idx = int'(cnt_q) - SYNC_BITS;

    always_ff @(posedge i_link_clk) begin
        if (l_rst || cnt_q == CNT_ZERO) begin
            feed_cnt_q <= CNT_ZERO;
        end else if (rs_feed) begin
            feed_cnt_q <= feed_cnt_q + CNT_ONE;
        end
    end

    a_sync_plain: assert property (@(posedge i_link_clk) disable iff (l_rst)
        (!mode_q && pos_q < BODY_FIRST_BIT && cnt_q != CNT_ZERO)
        |-> ser_q == SYNC_MARKER[SYNC_BITS - 1 - int'(pos_q)])
        else $error("sync marker bit wrong or randomized");
    a_prbs_head: assert property (@(posedge i_link_clk) disable iff (l_rst)
        (!mode_q && head_idx >= 0 && head_idx < PRBS_HEAD_LEN)
        |-> prbs_bit == PRBS_HEAD[PRBS_HEAD_LEN - 1 - head_idx])
        else $error("generator does not start with the fixed pattern");
    a_test_stream: assert property (@(posedge i_link_clk) disable iff (l_rst)
        mode_q |=> ser_q == $past(prbs_bit))
        else $error("test stream is not the generator output");
    a_pair_load: assert property (@(posedge i_link_clk) disable iff (l_rst)
        pos_q[0] |=> (o_chan.i == $past(pend_q) && o_chan.q == $past(ser_q)))
        else $error("serial pair not split first to I then to Q");
    a_chan_hold: assert property (@(posedge i_link_clk) disable iff (l_rst)
        !pos_q[0] |=> $stable(o_chan))
        else $error("channel level changed inside a channel bit");
    a_mode_wrap: assert property (@(posedge i_link_clk) disable iff (l_rst)
        $changed(mode_q) |-> cnt_q == CNT_ZERO)
        else $error("mode changed inside a frame");
    a_rate_step: assert property (@(posedge i_link_clk) disable iff (l_rst)
        cnt_q != CNT_ZERO |-> cnt_q == $past(cnt_q) + CNT_ONE)
        else $error("serial bit skipped or repeated");
    a_body_count: assert property (@(posedge i_link_clk) disable iff (l_rst)
        (!mode_q && cnt_q == PARITY_FIRST_BIT)
        |-> feed_cnt_q == CNT_W'(BODY_OCTETS))
        else $error("frame body octet count wrong");
    a_ack_space: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_octet_ready && i_octet.valid) |=> !o_octet_ready [*2])
        else $error("octet ready did not drop after transfer");

    c_test_on: cover property (@(posedge i_link_clk) disable iff (l_rst)
        $rose(mode_q));
    c_frame_done: cover property (@(posedge i_link_clk) disable iff (l_rst)
        !mode_q && cnt_q == CNT_LAST);
    c_underflow: cover property (@(posedge i_link_clk) disable iff (l_rst)
        $rose(l_unf_q));
    c_octet_take: cover property (@(posedge i_clk) disable iff (i_rst)
        o_octet_ready && i_octet.valid);

endmodule
